// ==== design/dsp_consts.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH
`define DSP_LANE_W 9
`define DSP_DLL_LOCK_K 2048
`define DSP_CAL_PERIOD 1024
`define DSP_REG_IMP_TGT 32'h0000_0000
`define DSP_REG_STATUS 32'h0000_0004
`define DSP_IMP_TGT_RST 8'h10
`define DSP_ST_DRV_LSB 0
`define DSP_ST_TRM_LSB 8
`define DSP_ST_LOCK_BIT 16
`define DSP_ST_RANGE_BIT 17
`define DSP_RESP_OKAY 2'h0
`define DSP_RESP_SLVERR 2'h2
`endif

// ==== design/dsp_mem.sv ====
// lane-maskable storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
module dsp_mem #(
    parameter int ADDR_W = 10,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    // clock
    input wire logic clk,
    // access
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rd_en,
    input wire logic [LANES-1:0] wr_lane,
    input wire logic [LANES*LANE_W-1:0] wdata,
    output logic [LANES*LANE_W-1:0] rdata
);
    genvar g;
    // one array per lane, so a masked lane is never rewritten
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] store [2**ADDR_W];
            always_ff @(posedge clk) begin
                if (wr_lane[g]) begin
                    store[addr] <= wdata[g*LANE_W +: LANE_W];
                end
                if (rd_en) begin
                    rdata[g*LANE_W +: LANE_W] <= store[addr];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== design/dsp_pkg.sv ====
// types shared by the sram port design
package dsp_pkg;
    typedef enum logic [1:0] {CMD_DESEL, CMD_READ, CMD_WRITE} dsp_cmd_t;
endpackage

// ==== design/dsp_sram_port.sv ====
// ddr common-io burst-of-two sram port with calibration and axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "dsp_consts.svh"
module dsp_sram_port
    import dsp_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 10,
    parameter int IMP_W = 6,
    parameter int CAL_PERIOD = `DSP_CAL_PERIOD
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register port
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory command pins
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic load_n,
    input wire logic rw_sel,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W/`DSP_LANE_W-1:0] byte_wr_en_n,
    // memory data pins
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic read_valid_out,
    output logic echo_clk,
    // impedance and dll pins
    input wire logic term_select,
    input wire logic impedance_ref_pin,
    input wire logic dll_enable,
    output logic [IMP_W-1:0] drive_code,
    output logic [IMP_W-1:0] term_code
);
    localparam int LANES = DATA_W / `DSP_LANE_W;
    localparam int PIN_W = 7 + ADDR_W + LANES + DATA_W;
    localparam int CAL_W = $clog2(CAL_PERIOD);
    localparam logic [11:0] LOCK_K = 12'(`DSP_DLL_LOCK_K);

    if (DATA_W % `DSP_LANE_W != 0 || DATA_W < `DSP_LANE_W || IMP_W < 2
        || IMP_W > 8 || CAL_PERIOD < 2 || ADDR_W < 1) begin : g_bad_param
        $error("dsp_sram_port: unsupported parameter values");
    end

    // pin synchronisers: every pin crosses from the memory clock domain
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic k_s, kb_s, load_n_s, rw_s, term_s, zq_s, dll_s;
    logic [ADDR_W-1:0] addr_s;
    logic [LANES-1:0] bw_s;
    logic [DATA_W-1:0] dq_s;
    logic k_prev_r, kb_prev_r;
    logic k_rise, kb_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {k_clk, k_clk_n, load_n, rw_sel, term_select,
                           impedance_ref_pin, dll_enable, addr_in,
                           byte_wr_en_n, dq_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign {k_s, kb_s, load_n_s, rw_s, term_s, zq_s, dll_s, addr_s, bw_s,
            dq_s} = pin_sync_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            k_prev_r <= 1'b0;
            kb_prev_r <= 1'b0;
            echo_clk <= 1'b0;
        end else begin
            k_prev_r <= k_s;
            kb_prev_r <= kb_s;
            echo_clk <= k_s;
        end
    end

    // all pins share one delay, so data stays aligned to its clock edge
    assign k_rise = k_s && !k_prev_r;
    assign kb_rise = kb_s && !kb_prev_r;

    // command decode and two-stage command pipeline
    dsp_cmd_t cmd_now, st1_cmd_r, st2_cmd_r;
    logic [ADDR_W-1:0] st1_addr_r, st2_addr_r;

    always_comb begin
        if (load_n_s) begin
            cmd_now = CMD_DESEL;
        end else if (rw_s) begin
            cmd_now = CMD_READ;
        end else begin
            cmd_now = CMD_WRITE;
        end
    end

    // a new command may land on every k rise, no gap needed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st1_cmd_r <= CMD_DESEL;
            st2_cmd_r <= CMD_DESEL;
            st1_addr_r <= '0;
            st2_addr_r <= '0;
        end else if (k_rise) begin
            st1_cmd_r <= cmd_now;
            st1_addr_r <= addr_s;
            st2_cmd_r <= st1_cmd_r;
            st2_addr_r <= st1_addr_r;
        end
    end

    // late write: beat one on the k after the command, beat two on kbar
    logic wr_pend_r;
    logic [DATA_W-1:0] wr_beat1_r;
    logic [LANES-1:0] bw1_r;
    logic [2*LANES-1:0] mem_wr_lane;
    logic mem_rd_en;
    logic [2*DATA_W-1:0] mem_rdata;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_pend_r <= 1'b0;
            wr_beat1_r <= '0;
            bw1_r <= '1;
        end else if (k_rise && st1_cmd_r == CMD_WRITE) begin
            wr_pend_r <= 1'b1;
            wr_beat1_r <= dq_s;
            bw1_r <= bw_s;
        end else if (kb_rise) begin
            wr_pend_r <= 1'b0;
        end
    end

    // both beats land in one wide word; a high enable keeps old contents
    assign mem_wr_lane = (kb_rise && wr_pend_r) ?
                         ~{bw_s, bw1_r} : '0;
    // the read fetch waits for kbar so an older write is already stored
    assign mem_rd_en = kb_rise && st2_cmd_r == CMD_READ;

    dsp_mem #(
        .ADDR_W(ADDR_W),
        .LANES(2 * LANES),
        .LANE_W(`DSP_LANE_W)
    ) u_mem (
        .clk(aclk),
        .addr(st2_addr_r),
        .rd_en(mem_rd_en),
        .wr_lane(mem_wr_lane),
        .wdata({dq_s, wr_beat1_r}),
        .rdata(mem_rdata)
    );

    // read drive: beat one on k two cycles on, beat two on next kbar
    logic rd2_pend_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
            read_valid_out <= 1'b0;
            rd2_pend_r <= 1'b0;
        end else if (k_rise) begin
            if (st2_cmd_r == CMD_READ) begin
                dq_out <= mem_rdata[DATA_W-1:0];
                dq_oe <= 1'b1;
                read_valid_out <= 1'b1;
                rd2_pend_r <= 1'b1;
            end else begin
                dq_oe <= 1'b0;
                read_valid_out <= 1'b0;
                rd2_pend_r <= 1'b0;
            end
        end else if (kb_rise && rd2_pend_r) begin
            dq_out <= mem_rdata[2*DATA_W-1:DATA_W];
            rd2_pend_r <= 1'b0;
        end
    end

    // dll lock tracking; reads before lock are the controller's hazard
    logic [11:0] lock_cnt_r;
    logic dll_locked;

    always_ff @(posedge aclk) begin
        if (!aresetn || !dll_s) begin
            lock_cnt_r <= '0;
        end else if (k_rise && lock_cnt_r != LOCK_K) begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
        end
    end

    assign dll_locked = lock_cnt_r == LOCK_K;

    // impedance calibration, free running, one step per evaluation
    logic [IMP_W-1:0] imp_tgt_r;
    logic [IMP_W-1:0] drv_tgt, trm_tgt;
    logic [CAL_W-1:0] cal_cnt_r;
    logic cal_tick;

    function automatic logic [IMP_W-1:0] step_toward(
        input logic [IMP_W-1:0] cur, input logic [IMP_W-1:0] tgt);
        if (cur < tgt) begin
            return cur + 1'b1;
        end else if (cur > tgt) begin
            return cur - 1'b1;
        end
        return cur;
    endfunction

    assign cal_tick = cal_cnt_r == CAL_W'(CAL_PERIOD - 1);
    // reference tied high forces the strongest driver code
    assign drv_tgt = zq_s ? '1 : imp_tgt_r;
    assign trm_tgt = term_s ? (drv_tgt >> 1) : drv_tgt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_cnt_r <= '0;
        end else if (cal_tick) begin
            cal_cnt_r <= '0;
        end else begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_code <= IMP_W'(`DSP_IMP_TGT_RST);
            term_code <= IMP_W'(`DSP_IMP_TGT_RST);
        end else if (cal_tick) begin
            drive_code <= step_toward(drive_code, drv_tgt);
            term_code <= step_toward(term_code, trm_tgt);
        end
    end

    // axi4-lite slave: one write and one read under way at most
    logic wr_go, ar_go, wr_rdy_r;
    logic [31:0] status_word;

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !wr_rdy_r && !s_axi_bvalid;
    assign ar_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign s_axi_awready = wr_rdy_r;
    assign s_axi_wready = wr_rdy_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_rdy_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DSP_RESP_OKAY;
            imp_tgt_r <= IMP_W'(`DSP_IMP_TGT_RST);
        end else begin
            wr_rdy_r <= wr_go;
            if (wr_rdy_r) begin
                s_axi_bvalid <= 1'b1;
                if (s_axi_awaddr == `DSP_REG_IMP_TGT) begin
                    s_axi_bresp <= `DSP_RESP_OKAY;
                    if (s_axi_wstrb[0]) begin
                        imp_tgt_r <= s_axi_wdata[IMP_W-1:0];
                    end
                end else if (s_axi_awaddr == `DSP_REG_STATUS) begin
                    s_axi_bresp <= `DSP_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `DSP_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        status_word = '0;
        status_word[`DSP_ST_DRV_LSB +: IMP_W] = drive_code;
        status_word[`DSP_ST_TRM_LSB +: IMP_W] = term_code;
        status_word[`DSP_ST_LOCK_BIT] = dll_locked;
        status_word[`DSP_ST_RANGE_BIT] = term_s;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `DSP_RESP_OKAY;
        end else begin
            s_axi_arready <= ar_go;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (s_axi_araddr == `DSP_REG_IMP_TGT) begin
                    s_axi_rdata <= 32'(imp_tgt_r);
                    s_axi_rresp <= `DSP_RESP_OKAY;
                end else if (s_axi_araddr == `DSP_REG_STATUS) begin
                    s_axi_rdata <= status_word;
                    s_axi_rresp <= `DSP_RESP_OKAY;
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `DSP_RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_due;
        k_rise && st2_cmd_r == CMD_READ;
    endsequence
    sequence s_wr_due;
        k_rise && st1_cmd_r == CMD_WRITE;
    endsequence

    chk_rd_first_beat: assert property (
        s_rd_due |=> dq_oe && read_valid_out
                     && dq_out == $past(mem_rdata[DATA_W-1:0]))
        else $error("read beat one not driven");
    chk_rd_second_beat: assert property (
        s_rd_due ##[1:8] kb_rise |=> dq_oe
                     && dq_out == $past(mem_rdata[2*DATA_W-1:DATA_W]))
        else $error("read beat two not driven");
    chk_valid_only_read: assert property (
        $rose(read_valid_out) |-> $past(k_rise)
                     && $past(st2_cmd_r) == CMD_READ && dq_oe)
        else $error("read valid without read beat");
    chk_nop_drivers_off: assert property (
        (k_rise && st2_cmd_r != CMD_READ) |=> !dq_oe && !read_valid_out)
        else $error("drivers on after nop or write");
    chk_load_ignored: assert property (
        (k_rise && load_n_s) |=> st1_cmd_r == CMD_DESEL)
        else $error("command taken with load high");
    chk_cmd_on_k_only: assert property (
        !k_rise |=> $stable(st1_cmd_r) && $stable(st1_addr_r))
        else $error("command sampled off a k rise");
    chk_wr_beat_one: assert property (
        s_wr_due |=> wr_pend_r && wr_beat1_r == $past(dq_s)
                     && bw1_r == $past(bw_s))
        else $error("write beat one not captured");
    chk_wr_commit: assert property (
        (kb_rise && wr_pend_r) |=> !wr_pend_r)
        else $error("write beat two not committed");
    chk_cal_one_step: assert property (
        cal_tick |=> drive_code == $past(drive_code)
                     || drive_code == $past(drive_code) + 1'b1
                     || drive_code == $past(drive_code) - 1'b1)
        else $error("impedance code moved more than one step");
    chk_cal_hold: assert property (
        !cal_tick |=> $stable(drive_code) && $stable(term_code))
        else $error("impedance code moved between evaluations");
endmodule
`default_nettype wire

// ==== sim/dsp_ctl_model.sv ====
// memory controller model: free k clocks, commands and late write data
`timescale 1ns/1ps
`default_nettype none
module dsp_ctl_model
    import dsp_pkg::*;
(
    // link clocks
    output logic k_clk,
    output logic k_clk_n,
    // command and data pins
    output logic load_n,
    output logic rw_sel,
    output logic [9:0] addr_in,
    output logic [1:0] byte_wr_en_n,
    output logic [17:0] dq_in,
    // lock wait over
    output logic ready
);
    typedef struct packed {
        dsp_cmd_t cmd;
        logic [9:0] addr;
        logic [35:0] data;
        logic [3:0] bwn;
    } dsp_op_t;
    dsp_op_t cq[$];
    dsp_op_t pend;
    dsp_op_t samp;
    dsp_op_t old;
    int kcount;
    task push(input dsp_cmd_t c, input logic [9:0] a, input logic [35:0] d,
              input logic [3:0] b);
        cq.push_back(dsp_op_t'({c, a, d, b}));
    endtask
    // idle lines show the inverse, so a stale copy never looks valid
    task beat(input logic [17:0] d, input logic [1:0] b, input logic en);
        dq_in = en ? d : ~dq_in;
        byte_wr_en_n = en ? b : ~byte_wr_en_n;
    endtask
    initial begin
        {k_clk, load_n, rw_sel, ready} = 4'h4;
        k_clk_n = 1'b1;
        {addr_in, byte_wr_en_n, dq_in} = '0;
        {pend, samp, old} = '0;
        kcount = 0;
        #3;
        // clock runs free: the lock logic needs it steady
        forever begin
            k_clk = 1'b1;
            k_clk_n = 1'b0;
            old = samp;
            samp = pend;
            kcount++;
            ready = kcount > 2048;
            #20;
            beat(old.data[35:18], old.bwn[3:2], old.cmd == CMD_WRITE);
            pend = (ready && cq.size() > 0) ? cq.pop_front() : '0;
            load_n = pend.cmd == CMD_DESEL;
            rw_sel = load_n ? ~rw_sel : pend.cmd == CMD_READ;
            addr_in = load_n ? ~addr_in : pend.addr;
            #20;
            k_clk = 1'b0;
            k_clk_n = 1'b1;
            #20;
            beat(samp.data[17:0], samp.bwn[1:0],
                 samp.cmd == CMD_WRITE);
            #20;
        end
    end
endmodule
`default_nettype wire

// ==== sim/dsp_sram_port_test.sv ====
// bench for the sram port: memory link, register port, calibration
`timescale 1ns/1ps
`default_nettype none
module dsp_sram_port_test
    import dsp_pkg::*;
;
    localparam int CAL = 16;
    logic aclk, aresetn, term_select, impedance_ref_pin, dll_enable;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic k_clk, k_clk_n, load_n, rw_sel, dq_oe, read_valid_out, echo_clk;
    logic [9:0] addr_in;
    logic [1:0] byte_wr_en_n;
    logic [17:0] dq_in, dq_out;
    logic [5:0] drive_code, term_code, last_code;
    logic [35:0] shadow [16];
    logic [17:0] expq[$];
    int err_total = 0;
    int compares = 0;
    int seed = 26964;
    int since;
    dsp_sram_port #(.CAL_PERIOD(CAL)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .load_n(load_n), .rw_sel(rw_sel), .addr_in(addr_in),
        .byte_wr_en_n(byte_wr_en_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .read_valid_out(read_valid_out),
        .echo_clk(echo_clk), .term_select(term_select),
        .impedance_ref_pin(impedance_ref_pin), .dll_enable(dll_enable),
        .drive_code(drive_code), .term_code(term_code));
    dsp_ctl_model ctl (
        .k_clk(k_clk), .k_clk_n(k_clk_n), .load_n(load_n), .rw_sel(rw_sel),
        .addr_in(addr_in), .byte_wr_en_n(byte_wr_en_n), .dq_in(dq_in),
        .ready());
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task tmo(input string nm);
        err_total++;
        $display("[FAIL] %s expected done got timeout", nm);
        finish_test;
    endtask
    task axi_wr(input logic [31:0] a, input logic [31:0] d,
                output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) tmo("axi write");
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task axi_rd(input logic [31:0] a, output logic [31:0] d,
                output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) tmo("axi read");
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // shadow follows issue order; reads see a write issued just before
    task mem_op(input dsp_cmd_t c, input logic [3:0] a, input logic [3:0] b);
        int lo;
        int hi;
        logic [35:0] d;
        lo = $random(seed);
        hi = $random(seed);
        d = {hi[3:0], lo};
        if (c == CMD_WRITE) begin
            for (int l = 0; l < 4; l++) begin
                if (!b[l]) shadow[a][l*9 +: 9] = d[l*9 +: 9];
            end
        end
        if (c == CMD_READ) begin
            expq.push_back(shadow[a][17:0]);
            expq.push_back(shadow[a][35:18]);
        end
        ctl.push(c, {6'h0, a}, d, b);
    endtask
    // beat one stands at the k-bar rise, beat two at the next k rise
    always @(posedge k_clk or posedge k_clk_n) begin
        if (aresetn === 1'b1) begin
            check("drivers", {31'h0, read_valid_out}, {31'h0, dq_oe});
            // the echo copy lags the pin, so only look once clocks settled
            if (ctl.ready === 1'b1)
                check("echo", {31'h0, ~k_clk}, {31'h0, echo_clk});
            if (read_valid_out === 1'b1) begin
                if (expq.size() == 0) begin
                    err_total++;
                    $display("[FAIL] read beat expected none got %h", dq_out);
                end else
                    check("read beat", {14'h0, expq.pop_front()},
                          {14'h0, dq_out});
            end
        end
    end
    always @(posedge aclk) begin
        if (aresetn !== 1'b1) begin
            last_code <= 6'h10;
            since <= 0;
        end else if (drive_code !== last_code) begin
            check("code step", 32'h1, {31'h0,
                  (drive_code - last_code) === 6'h01
                  || (last_code - drive_code) === 6'h01});
            check("code spacing", 32'h1, {31'h0, since >= CAL - 1});
            last_code <= drive_code;
            since <= 0;
        end else
            since <= since + 1;
    end
    initial begin
        logic [31:0] rd;
        logic [1:0] rs;
        int r;
        int n;
        {aresetn, term_select, impedance_ref_pin} = 3'h0;
        dll_enable = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(32'h0, rd, rs);
        check("target reset", 32'h10, rd);
        axi_rd(32'h4, rd, rs);
        check("status reset", 32'h1010, rd);
        axi_rd(32'h8, rd, rs);
        check("unmapped read", 32'h2, {30'h0, rs});
        check("unmapped data", 32'h0, rd);
        axi_wr(32'hc, 32'h3f, rs);
        check("unmapped write", 32'h2, {30'h0, rs});
        $display("test registers done");
        // every mask code, each followed at once by a read
        for (int b = 0; b < 16; b++) begin
            mem_op(CMD_WRITE, b[3:0], 4'h0);
            mem_op(CMD_WRITE, b[3:0], b[3:0]);
            mem_op(CMD_READ, b[3:0], 4'hf);
        end
        for (int i = 0; i < 80; i++) begin
            r = $random(seed);
            mem_op(r[1:0] == 2'h3 ? CMD_READ : dsp_cmd_t'(r[1:0]),
                   r[11:8], r[7:4]);
        end
        n = 0;
        while ((expq.size() > 0 || ctl.cq.size() > 0) && n < 30000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 30000) tmo("memory traffic");
        repeat (60) @(posedge aclk);
        check("beats left", 32'h0, expq.size());
        $display("test memory done");
        term_select <= 1'b1;
        axi_wr(32'h0, 32'h2a, rs);
        check("target write", 32'h0, {30'h0, rs});
        axi_rd(32'h0, rd, rs);
        check("target read", 32'h2a, rd);
        repeat (600) @(posedge aclk);
        axi_rd(32'h4, rd, rs);
        check("cal high range", 32'h0003152a, rd);
        term_select <= 1'b0;
        repeat (600) @(posedge aclk);
        axi_rd(32'h4, rd, rs);
        check("cal low range", 32'h00012a2a, rd);
        impedance_ref_pin <= 1'b1;
        repeat (600) @(posedge aclk);
        check("drive ref", 32'h3f, {26'h0, drive_code});
        $display("test calibration done");
        finish_test;
    end
endmodule
`default_nettype wire
